// ==== src/adcc_pkg.sv ====
// *****************************************************************
// Shared constants for the converter control block.
// *****************************************************************
package adcc_pkg;

  // *****************************************************************
  // Widths.
  // *****************************************************************
  localparam int ADDR_W     = 4;   // Register address width.
  localparam int DATA_W     = 8;   // Register data width.
  localparam int RESULT_W   = 12;  // Conversion result width.
  localparam int CHAN_W     = 4;   // Channel select field width.
  localparam int SRC_COUNT  = 13;  // Eleven plus one inputs and the reference.

  // *****************************************************************
  // Register offsets.
  // *****************************************************************
  localparam logic [3:0] OFF_CONTROL_0 = 4'h0;  // Start, busy, power, format, channel.
  localparam logic [3:0] OFF_CONTROL_1 = 4'h1;  // Reference route bit.
  localparam logic [3:0] OFF_RESULT_HI = 4'h2;  // Result high byte.
  localparam logic [3:0] OFF_RESULT_LO = 4'h3;  // Result low byte.
  localparam logic [3:0] OFF_INT_STAT  = 4'h4;  // Sticky event bits, write one to clear.
  localparam logic [3:0] OFF_INT_MASK  = 4'h5;  // Interrupt enables.

  // *****************************************************************
  // Field positions in the first control register.
  // *****************************************************************
  localparam int POS_START  = 7;   // Start strobe bit.
  localparam int POS_BUSY   = 6;   // Conversion busy flag.
  localparam int POS_OFF    = 5;   // Converter power off.
  localparam int POS_FORMAT = 4;   // Result format select.
  localparam int POS_CHAN   = 0;   // Low bit of the channel field.

  // Field positions in the second control register and the status register.
  localparam int POS_REF_ROUTE = 4;  // Reference route bit.
  localparam int POS_EV_DONE   = 0;  // Conversion complete event.

  // *****************************************************************
  // Reset values and limits.
  // *****************************************************************
  localparam logic [7:0] RST_CONTROL_0 = 8'h60;  // Start 0, busy 1, off 1, format 0.
  localparam logic [7:0] RST_CONTROL_1 = 8'h00;  // Reference not routed.
  localparam logic [3:0] CHAN_LAST     = 4'hB;   // Highest defined channel code.
  localparam int         REF_SRC       = 12;     // Mux position of the reference.

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_CONV  = 3'b100
  } adcc_state_t;

endpackage : adcc_pkg

// ==== src/adcc_result_regs.sv ====
`timescale 1ns/1ns
// *****************************************************************
// Holds the two result bytes, arranged at capture time.
// *****************************************************************
module adcc_result_regs
  import adcc_pkg::*;
(
  // Clock and reset.
  input  wire logic                clock,
  input  wire logic                rst,
  // Capture request.
  input  wire logic                load,
  input  wire logic [RESULT_W-1:0] result,
  input  wire logic                right_justify,
  // Stored bytes.
  output logic      [DATA_W-1:0]   high_q,
  output logic      [DATA_W-1:0]   low_q
);

  logic [DATA_W-1:0] high_d;  // Next high byte.
  logic [DATA_W-1:0] low_d;   // Next low byte.

  // Arrange the result; the bytes only move on a load so that software
  // always reads the last finished conversion.
  always_comb
  begin
    high_d = high_q;
    low_d  = low_q;
    if (load)
    begin
      if (right_justify)
      begin
        high_d = {4'h0, result[11:8]};
        low_d  = result[7:0];
      end
      else
      begin
        high_d = result[11:4];
        low_d  = {result[3:0], 4'h0};
      end
    end
  end

  // Register the bytes.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      high_q <= 8'h00;
      low_q  <= 8'h00;
    end
    else
    begin
      high_q <= high_d;
      low_q  <= low_d;
    end
  end

endmodule : adcc_result_regs

// ==== src/adcc_control.sv ====
`timescale 1ns/1ns
module adcc_control
  import adcc_pkg::*;
(
  // Clock and reset.
  input  wire logic                 clock,
  input  wire logic                 rst,
  // Register port.
  input  wire logic [ADDR_W-1:0]    addr,
  input  wire logic [DATA_W-1:0]    wr_data,
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  output logic      [DATA_W-1:0]    rd_data,
  // Converter core.
  input  wire logic                 conv_done,
  input  wire logic [RESULT_W-1:0]  conv_result,
  output logic                      conv_reset,
  output logic                      conv_start,
  output logic                      conv_power_off,
  // Analog multiplexer, one bit per source.
  output logic      [SRC_COUNT-1:0] analog_select,
  // Interrupt.
  output logic                      irq
);

  // *****************************************************************
  // Declarations.
  // *****************************************************************
  adcc_state_t              state_q;       // Sequencer state.
  adcc_state_t              state_d;       // Next sequencer state.
  logic                     start_q;       // Start bit as written.
  logic                     start_d;       // Next start bit.
  logic                     busy_q;        // Conversion busy flag.
  logic                     busy_d;        // Next busy flag.
  logic                     off_q;         // Converter power off.
  logic                     off_d;         // Next power off.
  logic                     format_q;      // Result format select.
  logic                     format_d;      // Next format select.
  logic [CHAN_W-1:0]        chan_q;        // Channel select field.
  logic [CHAN_W-1:0]        chan_d;        // Next channel select.
  logic                     ref_q;         // Reference route bit.
  logic                     ref_d;         // Next reference route bit.
  logic                     cstart_q;      // Start pulse to the core.
  logic                     cstart_d;      // Next start pulse.
  logic                     creset_q;      // Reset pulse to the core.
  logic                     creset_d;      // Next reset pulse.
  logic                     load_res;      // Capture the result this cycle.
  logic                     ev_done;       // Conversion complete event.
  logic [SRC_COUNT-1:0]     sel_q;         // Registered mux select.
  logic [SRC_COUNT-1:0]     sel_d;         // Next mux select.
  logic [DATA_W-1:0]        stat_q;        // Sticky event bits.
  logic [DATA_W-1:0]        stat_d;        // Next event bits.
  logic [DATA_W-1:0]        mask_q;        // Interrupt mask.
  logic [DATA_W-1:0]        mask_d;        // Next interrupt mask.
  logic                     irq_q;         // Registered interrupt.
  logic                     irq_d;         // Next interrupt.
  logic [DATA_W-1:0]        rd_q;          // Registered read data.
  logic [DATA_W-1:0]        rd_d;          // Next read data.
  logic [DATA_W-1:0]        res_hi;        // Stored high result byte.
  logic [DATA_W-1:0]        res_lo;        // Stored low result byte.
  logic [DATA_W-1:0]        ctrl0_view;    // First control register as read.
  logic                     wr_ctrl0;      // Write to the first control register.
  logic                     new_start;     // Start bit in the write data.

  // *****************************************************************
  // Control register writes and start sequencing.
  // *****************************************************************

  assign wr_ctrl0  = wr_en && (addr == OFF_CONTROL_0);
  assign new_start = wr_data[POS_START];

  // Decode writes to the control registers and walk the conversion
  // sequence. The busy flag has no write path of its own.
  always_comb
  begin
    state_d  = state_q;
    start_d  = start_q;
    busy_d   = busy_q;
    off_d    = off_q;
    format_d = format_q;
    chan_d   = chan_q;
    ref_d    = ref_q;
    cstart_d = 1'b0;
    creset_d = 1'b0;
    load_res = 1'b0;
    ev_done  = 1'b0;
    if (wr_ctrl0)
    begin
      off_d    = wr_data[POS_OFF];
      format_d = wr_data[POS_FORMAT];
      if (wr_data[POS_CHAN +: CHAN_W] <= CHAN_LAST)
      begin
        chan_d = wr_data[POS_CHAN +: CHAN_W];
      end
    end
    if (wr_en && (addr == OFF_CONTROL_1))
    begin
      ref_d = wr_data[POS_REF_ROUTE];
    end
    unique case (state_q)
      ST_IDLE:
      begin
        if (wr_ctrl0 && new_start && !off_q)
        begin
          start_d  = 1'b1;
          busy_d   = 1'b1;
          creset_d = 1'b1;
          state_d  = ST_ARMED;
        end
      end
      ST_ARMED:
      begin
        if (off_q)
        begin
          // Power went away while armed; drop the strobe, keep busy.
          start_d = 1'b0;
          state_d = ST_IDLE;
        end
        else if (wr_ctrl0 && !new_start)
        begin
          start_d  = 1'b0;
          cstart_d = 1'b1;
          state_d  = ST_CONV;
        end
        else if (wr_ctrl0)
        begin
          // A repeated high write restarts the reset phase.
          creset_d = 1'b1;
        end
      end
      ST_CONV:
      begin
        if (off_q)
        begin
          state_d = ST_IDLE;
        end
        else if (wr_ctrl0 && new_start)
        begin
          start_d  = 1'b1;
          creset_d = 1'b1;
          state_d  = ST_ARMED;
        end
        else if (conv_done)
        begin
          busy_d   = 1'b0;
          load_res = 1'b1;
          ev_done  = 1'b1;
          state_d  = ST_IDLE;
        end
      end
    endcase
  end

  // Register the control state. reset values come from the package.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q  <= ST_IDLE;
      start_q  <= RST_CONTROL_0[POS_START];
      busy_q   <= RST_CONTROL_0[POS_BUSY];
      off_q    <= RST_CONTROL_0[POS_OFF];
      format_q <= RST_CONTROL_0[POS_FORMAT];
      chan_q   <= RST_CONTROL_0[POS_CHAN +: CHAN_W];
      ref_q    <= RST_CONTROL_1[POS_REF_ROUTE];
      cstart_q <= 1'b0;
      creset_q <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      start_q  <= start_d;
      busy_q   <= busy_d;
      off_q    <= off_d;
      format_q <= format_d;
      chan_q   <= chan_d;
      ref_q    <= ref_d;
      cstart_q <= cstart_d;
      creset_q <= creset_d;
    end
  end

  // *****************************************************************
  // Result bytes.
  // *****************************************************************

  // The format in force when the conversion ends decides the layout.
  adcc_result_regs u_result (
    .clock         (clock),
    .rst           (rst),
    .load          (load_res),
    .result        (conv_result),
    .right_justify (format_q),
    .high_q        (res_hi),
    .low_q         (res_lo)
  );

  // *****************************************************************
  // Analog source selection.
  // *****************************************************************

  // One-hot select, so two sources can never short together. Undefined
  // channel codes never reach chan_q, which keeps the decode total.
  always_comb
  begin
    sel_d = '0;
    if (ref_q)
    begin
      sel_d[REF_SRC] = 1'b1;
    end
    else
    begin
      sel_d[chan_q] = 1'b1;
    end
  end

  // Register the select.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sel_q <= 13'h0001;
    end
    else
    begin
      sel_q <= sel_d;
    end
  end

  // *****************************************************************
  // Interrupt status, mask and read port.
  // *****************************************************************

  assign ctrl0_view = {start_q, busy_q, off_q, format_q, chan_q};

  // Status bits are write-one-to-clear; a new event in the same cycle wins.
  always_comb
  begin
    stat_d = stat_q;
    mask_d = mask_q;
    rd_d   = 8'h00;
    if (wr_en && (addr == OFF_INT_STAT))
    begin
      stat_d = stat_q & ~wr_data;
    end
    if (wr_en && (addr == OFF_INT_MASK))
    begin
      mask_d = wr_data;
    end
    if (ev_done)
    begin
      stat_d[POS_EV_DONE] = 1'b1;
    end
    irq_d = |(stat_d & mask_d);
    if (rd_en)
    begin
      unique case (addr)
        OFF_CONTROL_0: rd_d = ctrl0_view;
        OFF_CONTROL_1: rd_d = {3'h0, ref_q, 4'h0};
        OFF_RESULT_HI: rd_d = res_hi;
        OFF_RESULT_LO: rd_d = res_lo;
        OFF_INT_STAT:  rd_d = stat_q;
        OFF_INT_MASK:  rd_d = mask_q;
        // Unmapped addresses read as zero.
        default:       rd_d = 8'h00;
      endcase
    end
  end

  // Register status, mask, interrupt and read data.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stat_q <= 8'h00;
      mask_q <= 8'h00;
      irq_q  <= 1'b0;
      rd_q   <= 8'h00;
    end
    else
    begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= irq_d;
      rd_q   <= rd_d;
    end
  end

  // *****************************************************************
  // Outputs, all straight from flip-flops.
  // *****************************************************************
  assign rd_data        = rd_q;
  assign conv_reset     = creset_q;
  assign conv_start     = cstart_q;
  assign conv_power_off = off_q;
  assign analog_select  = sel_q;
  assign irq            = irq_q;

endmodule : adcc_control

// ==== dv/adcc_core_model.sv ====
`timescale 1ns/1ns
// *****************************************************************
// Converter core model: answers a start after a set latency.
// *****************************************************************
module adcc_core_model
  import adcc_pkg::*;
(
  // Clock and reset.
  input  wire logic                clock,
  input  wire logic                rst,
  // Control from the block.
  input  wire logic                conv_reset,
  input  wire logic                conv_start,
  input  wire logic                conv_power_off,
  // Bench settings: latency and the value to return.
  input  wire logic [3:0]          lat,
  input  wire logic [RESULT_W-1:0] value,
  // Answer to the block.
  output logic                     conv_done,
  output logic [RESULT_W-1:0]      conv_result
);
  logic       run_q;  // A conversion is in flight.
  logic [3:0] cnt_q;  // Cycles left before the answer.

  // The result is only valid with the done pulse; otherwise it shows
  // the inverse so that a capture at the wrong moment is caught.
  assign conv_result = conv_done ? value : ~value;

  // power off or reset drops a conversion in flight.
  always_ff @(posedge clock)
  begin
    conv_done <= 1'b0;
    if (rst || conv_reset || conv_power_off)
    begin
      run_q <= 1'b0;
    end
    else if (conv_start)
    begin
      run_q <= 1'b1;
      cnt_q <= lat;
    end
    else if (run_q && cnt_q == 4'h0)
    begin
      run_q     <= 1'b0;
      conv_done <= 1'b1;
    end
    else if (run_q)
    begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule : adcc_core_model

// ==== dv/adcc_control_chk.sv ====
`timescale 1ns/1ns
// *****************************************************************
// Port checker for the control block.
// *****************************************************************
module adcc_control_chk
  import adcc_pkg::*;
(
  // Clock and reset.
  input wire logic                 clock,
  input wire logic                 rst,
  // Register port.
  input wire logic [ADDR_W-1:0]    addr,
  input wire logic [DATA_W-1:0]    wr_data,
  input wire logic                 wr_en,
  // Converter side.
  input wire logic                 conv_reset,
  input wire logic                 conv_start,
  input wire logic                 conv_power_off,
  input wire logic [SRC_COUNT-1:0] analog_select,
  input wire logic                 irq
);
  logic                 wr0;        // Write to the first control register.
  logic                 wr1;        // Write to the second control register.
  logic [CHAN_W-1:0]    chan_q;     // Last accepted channel code.
  logic                 ref_q;      // Reference routing as last written.
  logic [SRC_COUNT-1:0] sel_exp_q;  // Expected select, one cycle behind the fields.
  assign wr0 = wr_en && addr == OFF_CONTROL_0;
  assign wr1 = wr_en && addr == OFF_CONTROL_1;

  // Mirror of the mux state; undefined codes leave the channel alone.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      chan_q    <= '0;
      ref_q     <= 1'b0;
      sel_exp_q <= 13'h0001;
    end
    else
    begin
      // The block registers its select a cycle after the fields change.
      sel_exp_q <= ref_q ? 13'h1000 : 13'h0001 << chan_q;
      if (wr0 && wr_data[3:0] <= CHAN_LAST)
      begin
        chan_q <= wr_data[3:0];
      end
      if (wr1)
      begin
        ref_q <= wr_data[POS_REF_ROUTE];
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_start_cause:
    assert property (conv_start |-> $past(wr0 && !wr_data[POS_START]))
    else $error("start pulse without a start clear write");
  a_reset_cause:
    assert property (conv_reset |-> $past(wr0 && wr_data[POS_START]))
    else $error("core reset without a start set write");
  a_power_follow:
    assert property ($past(wr0) |-> conv_power_off == $past(wr_data[POS_OFF]))
    else $error("power off output does not follow the write");
  a_select_map:
    assert property (analog_select == sel_exp_q)
    else $error("mux select does not match the channel");
  a_select_onehot:
    assert property ($onehot(analog_select))
    else $error("mux select is not one hot");
  a_ref_route:
    assert property (wr1 && wr_data[POS_REF_ROUTE] |-> ##2 analog_select[REF_SRC])
    else $error("reference not routed after route write");
  a_reset_defaults:
    assert property ($fell(rst) |-> conv_power_off && analog_select == 13'h0001 && !irq)
    else $error("outputs wrong after reset");
  a_off_blocks:
    assert property (conv_reset |-> !$past(conv_power_off))
    else $error("start accepted while powered off");
endmodule : adcc_control_chk

// ==== dv/adcc_control_bench.sv ====
`timescale 1ns/1ns
// *****************************************************************
// Self-checking bench for the control block.
// *****************************************************************
module adcc_control_bench
  import adcc_pkg::*;
;
  logic                 clock = 1'b0;  // 20 MHz clock.
  logic                 rst   = 1'b1;  // Synchronous reset.
  logic [ADDR_W-1:0]    addr  = '0;    // Register address.
  logic [DATA_W-1:0]    wr_data = '0;  // Write data.
  logic                 wr_en = 1'b0;  // Write strobe.
  logic                 rd_en = 1'b0;  // Read strobe.
  logic [DATA_W-1:0]    rd_data;       // Read data.
  logic                 conv_done, conv_reset, conv_start, conv_power_off, irq;
  logic [RESULT_W-1:0]  conv_result;   // Core result.
  logic [SRC_COUNT-1:0] analog_select; // Mux select.
  logic [3:0]           lat = 4'h0;    // Core latency.
  logic [RESULT_W-1:0]  val = '0;      // Core value.
  logic [DATA_W-1:0]    v;             // Last read value.
  int                   error_cnt = 0;
  int                   compares  = 0;
  int                   cyc       = 0;

  adcc_control u_dut (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .conv_done(conv_done),
    .conv_result(conv_result), .conv_reset(conv_reset), .conv_start(conv_start),
    .conv_power_off(conv_power_off), .analog_select(analog_select), .irq(irq));
  adcc_core_model u_core (.clock(clock), .rst(rst), .conv_reset(conv_reset),
    .conv_start(conv_start), .conv_power_off(conv_power_off), .lat(lat),
    .value(val), .conv_done(conv_done), .conv_result(conv_result));

  // Clock generation, 50 ns period.
  always #25 clock = ~clock;

  // A hang is cut short well after the tests should have ended.
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // Compares one value against its expectation.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write; returns just after the edge that takes it.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  // One-cycle read; data are taken in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  // Lets one more edge pass, for outputs registered a cycle after a write.
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick

  // Full conversion: start set, start clear, then poll busy.
  task automatic conv(input logic f, input logic [3:0] ch, input logic [11:0] x,
                      input logic [3:0] l);
    val = x;
    lat = l;
    wr(OFF_CONTROL_0, {3'b100, f, ch});
    chk(conv_reset, 1'b1);
    rd(OFF_CONTROL_0, v);
    chk(v[POS_BUSY], 1'b1);
    wr(OFF_CONTROL_0, {3'b000, f, ch});
    chk(conv_start, 1'b1);
    for (int i = 0; i < 30 && v[POS_BUSY] !== 1'b0; i++)
      rd(OFF_CONTROL_0, v);
    chk(v, {3'b000, f, ch});
  endtask : conv

  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(OFF_CONTROL_0, v);
    chk(v, 8'h60);
    chk(analog_select, 13'h0001);
    wr(OFF_CONTROL_0, 8'hA0);
    chk(conv_reset, 1'b0);
    wr(OFF_CONTROL_0, 8'h00);
    chk(conv_power_off, 1'b0);
    wr(OFF_INT_MASK, 8'h01);
    // Prompt core, left-justified result.
    conv(1'b0, 4'h5, 12'hABC, 4'h0);
    rd(OFF_RESULT_HI, v);
    chk(v, 8'hAB);
    rd(OFF_RESULT_LO, v);
    chk(v, 8'hC0);
    chk(irq, 1'b1);
    wr(OFF_INT_STAT, 8'h01);
    rd(OFF_INT_STAT, v);
    chk(irq, 1'b0);
    // Slow core, right-justified, interrupt masked meanwhile.
    wr(OFF_INT_MASK, 8'h00);
    conv(1'b1, 4'hB, 12'h5A3, 4'h9);
    rd(OFF_RESULT_HI, v);
    chk(v, 8'h05);
    rd(OFF_RESULT_LO, v);
    chk(v, 8'hA3);
    chk(irq, 1'b0);
    wr(OFF_INT_MASK, 8'h01);
    rd(OFF_INT_STAT, v);
    chk(v, 8'h01);
    chk(irq, 1'b1);
    wr(OFF_INT_STAT, 8'h01);
    // Every defined channel, then an undefined code that is refused.
    // loop keeps to defined codes
    for (int n = 0; n < 12; n++)
    begin
      wr(OFF_CONTROL_0, 8'(n));
      tick();
      chk(analog_select, 13'h0001 << n);
    end
    wr(OFF_CONTROL_0, 8'h0C);
    tick();
    chk(analog_select, 13'h0800);
    wr(OFF_CONTROL_1, 8'h10);
    tick();
    chk(analog_select, 13'h1000);
    rd(OFF_CONTROL_1, v);
    chk(v, 8'h10);
    wr(4'hF, 8'hFF);
    rd(4'hF, v);
    chk(v, 8'h00);
    // A written busy bit must not stick, since the flag is read only.
    wr(OFF_CONTROL_0, 8'h40);
    rd(OFF_CONTROL_0, v);
    chk(v, 8'h00);
    // Power down before sleeping.
    wr(OFF_CONTROL_0, 8'h20);
    chk(conv_power_off, 1'b1);
    // Power lost mid-conversion aborts it, keeps busy and the old result.
    wr(OFF_CONTROL_0, 8'h00);
    wr(OFF_CONTROL_0, 8'h80);
    wr(OFF_CONTROL_0, 8'h00);
    wr(OFF_CONTROL_0, 8'h20);
    rd(OFF_CONTROL_0, v);
    chk(v, 8'h60);
    rd(OFF_RESULT_HI, v);
    chk(v, 8'h05);
    end_sim();
  end
endmodule : adcc_control_bench

bind adcc_control adcc_control_chk u_chk (.clock(clock), .rst(rst), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .conv_reset(conv_reset), .conv_start(conv_start),
  .conv_power_off(conv_power_off), .analog_select(analog_select), .irq(irq));
